// ### logic/complementary_waveform_unit.sv
// complementary / push-pull waveform generator with axi4-lite registers
// assumes: event, fault, limit and clock pins may be asynchronous
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`include "cwu_defines.svh"
module complementary_waveform_unit #(
  parameter int unsigned CLK_DIV = `CWU_CLK_DIV
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire logic rise_event_in,
  input wire logic fall_event_in,
  input wire logic fault_in,
  input wire logic hlt_event_in,
  input wire logic gen_clk_pin_in,
  output logic out0_out,
  output logic out0_oe_out,
  output logic out1_out,
  output logic out1_oe_out
);
  // ==================================================
  // functions
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r & mask;
  endfunction

  function automatic cwu_pkg::reg_sel_t decode(input logic [7:0] a);
    unique case (a)
      `CWU_CTRL_OFS: return cwu_pkg::REG_CTRL;
      `CWU_SHDN_OFS: return cwu_pkg::REG_SHDN;
      `CWU_RISE_OFS: return cwu_pkg::REG_RISE;
      `CWU_FALL_OFS: return cwu_pkg::REG_FALL;
      `CWU_STAT_OFS: return cwu_pkg::REG_STAT;
      default: return cwu_pkg::REG_NONE;
    endcase
  endfunction

  // pin level and enable from override, active state and polarity
  function automatic logic [1:0] pin_drive(input logic sd, input logic [1:0] ovr,
                                           input logic act, input logic pol, input logic en);
    if (!sd) begin
      return {act ^ pol, en};
    end
    unique case (cwu_pkg::override_t'(ovr))
      cwu_pkg::OVR_OFF: return {pol, en};
      cwu_pkg::OVR_LOW: return {1'b0, en};
      cwu_pkg::OVR_HIGH: return {1'b1, en};
      cwu_pkg::OVR_HIZ: return {pol, 1'b0};
    endcase
  endfunction

  // ==================================================
  // registers and state
  logic [31:0] ctrl_q, shdn_q, rise_q, fall_q, work_rise_q, work_fall_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [4:0] sync1_q, sync2_q;
  logic prev_rise_q, prev_fall_q, prev_clk_q, prev_hlt_q;
  logic [7:0] div_q;
  cwu_pkg::drive_state_t st_q, st_d;
  logic drive_q, drive_d, pin_sel_q;
  logic out0_q, oe0_q, out1_q, oe1_q;
  logic wr_go, wr_ctrl, run, gen_tick, div_tick;
  logic rise_src, fall_src, rise_hit, fall_hit, rise_ev, fall_ev;
  logic fault_now, hlt_ev, bk_dir_q, act0, act1, xfer;
  logic [1:0] drv0, drv1;
  cwu_pkg::reg_sel_t wsel;

  cwu_timer_if ph_if ();
  cwu_timer_if bk_if ();
  cwu_timer_if db_if ();

  interval_counter u_phase (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .tmr(ph_if.counter));
  interval_counter u_blank (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .tmr(bk_if.counter));
  interval_counter u_dead (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .tmr(db_if.counter));

  // ==================================================
  // axi4-lite write channel
  // address and data are taken in either order; the write fires when both are held
  assign awready_out = !aw_hold_q && !bvalid_q;
  assign wready_out = !w_hold_q && !bvalid_q;
  assign bvalid_out = bvalid_q;
  assign bresp_out = bresp_q;
  assign wr_go = aw_hold_q && w_hold_q;
  assign wsel = decode(awaddr_q);
  assign wr_ctrl = wr_go && wsel == cwu_pkg::REG_CTRL;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        w_hold_q <= 1'b1;
        wdata_q <= wdata_in;
        wstrb_q <= wstrb_in;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wsel == cwu_pkg::REG_NONE) ? 2'h2 : 2'h0; // slverr on unmapped
      end else if (bvalid_q && bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==================================================
  // axi4-lite read channel
  assign arready_out = !rvalid_q;
  assign rvalid_out = rvalid_q;
  assign rdata_out = rdata_q;
  assign rresp_out = rresp_q;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else if (arvalid_in && arready_out) begin
      rvalid_q <= 1'b1;
      rresp_q <= 2'h0;
      unique case (decode(araddr_in))
        cwu_pkg::REG_CTRL: rdata_q <= ctrl_q;
        cwu_pkg::REG_SHDN: rdata_q <= shdn_q;
        cwu_pkg::REG_RISE: rdata_q <= rise_q;
        cwu_pkg::REG_FALL: rdata_q <= fall_q;
        cwu_pkg::REG_STAT: rdata_q <= {20'h0_0000, st_q, 3'h0, sync2_q[2], pin_sel_q, drive_q, out1_q, out0_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= 2'h2;
        end
      endcase
    end else if (rvalid_q && rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==================================================
  // control and shutdown registers with hardware side effects
  assign xfer = ctrl_q[`CWU_EN] && ctrl_q[`CWU_LD] && st_q == cwu_pkg::ST_OFF;
  assign fault_now = shdn_q[`CWU_FLTEN] && sync2_q[2];

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q <= `CWU_CTRL_RST;
      shdn_q <= `CWU_SHDN_RST;
    end else begin
      // load bit: hardware clear loses to a software set in the same cycle
      if (xfer) begin
        ctrl_q[`CWU_LD] <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q, `CWU_CTRL_MASK);
      end
      if (wr_go && wsel == cwu_pkg::REG_SHDN) begin
        shdn_q <= merge(shdn_q, wdata_q, wstrb_q, `CWU_SHDN_MASK);
      end
      // auto-restart clears only once the fault is gone, else it would chatter
      if (shdn_q[`CWU_ARS] && !fault_now) begin
        shdn_q[`CWU_SDACT] <= 1'b0;
      end
      if (fault_now) begin
        shdn_q[`CWU_SDACT] <= 1'b1;
      end
    end
  end

  // ==================================================
  // count registers and their working copies
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rise_q <= `CWU_TIME_RST;
      fall_q <= `CWU_TIME_RST;
      work_rise_q <= `CWU_TIME_RST;
      work_fall_q <= `CWU_TIME_RST;
    end else begin
      if (wr_go && wsel == cwu_pkg::REG_RISE) begin
        rise_q <= merge(rise_q, wdata_q, wstrb_q, `CWU_TIME_MASK);
      end
      if (wr_go && wsel == cwu_pkg::REG_FALL) begin
        fall_q <= merge(fall_q, wdata_q, wstrb_q, `CWU_TIME_MASK);
      end
      // working copies change only between periods so a set of counts acts together
      if (!ctrl_q[`CWU_EN] || xfer) begin
        work_rise_q <= rise_q;
        work_fall_q <= fall_q;
      end
    end
  end

  // ==================================================
  // synchronisers: rise, fall, fault, limit timer, clock pin
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {gen_clk_pin_in, hlt_event_in, fault_in, fall_event_in, rise_event_in};
      sync2_q <= sync1_q;
    end
  end

  // edge history on the synchronised copies only
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_rise_q <= 1'b0;
      prev_fall_q <= 1'b0;
      prev_hlt_q <= 1'b0;
      prev_clk_q <= 1'b0;
    end else begin
      prev_rise_q <= rise_src;
      prev_fall_q <= fall_src;
      prev_hlt_q <= sync2_q[3];
      prev_clk_q <= sync2_q[4];
    end
  end

  // ==================================================
  // generator tick select
  // the pin clock is limited to under half the system clock rate
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_tick ? 8'h00 : div_q + 8'h01;
    end
  end
  assign div_tick = (div_q == 8'(CLK_DIV - 1));

  always_comb begin
    unique case (ctrl_q[`CWU_CSEL])
      cwu_pkg::CLK_DIVIDED: gen_tick = div_tick;
      cwu_pkg::CLK_PIN: gen_tick = sync2_q[4] && !prev_clk_q;
      default: gen_tick = 1'b1;
    endcase
  end

  // ==================================================
  // event detection and blanking
  // a falling source may be the falling edge of the rising input
  assign rise_src = sync2_q[0];
  assign fall_src = ctrl_q[`CWU_FSAME] ? !sync2_q[0] : sync2_q[1];
  assign rise_hit = rise_src && (ctrl_q[`CWU_RLVL] || !prev_rise_q);
  assign fall_hit = fall_src && (ctrl_q[`CWU_FLVL] || !prev_fall_q);
  assign hlt_ev = shdn_q[`CWU_HLTEN] && sync2_q[3] && !prev_hlt_q;
  assign rise_ev = rise_hit && !(bk_if.busy && !bk_dir_q);
  assign fall_ev = (fall_hit && !(bk_if.busy && bk_dir_q)) || hlt_ev;
  assign run = ctrl_q[`CWU_EN] && !shdn_q[`CWU_SDACT];

  // ==================================================
  // drive state machine with phase delay
  always_comb begin
    st_d = st_q;
    ph_if.start = 1'b0;
    ph_if.len = work_rise_q[`CWU_PH];
    unique case (st_q)
      cwu_pkg::ST_OFF: begin
        if (rise_ev) begin
          if (work_rise_q[`CWU_PH] == 8'h00) begin
            st_d = cwu_pkg::ST_ON;
          end else begin
            st_d = cwu_pkg::ST_WAIT_ON;
            ph_if.start = 1'b1;
          end
        end
      end
      cwu_pkg::ST_WAIT_ON: begin
        if (fall_ev) begin
          st_d = cwu_pkg::ST_OFF;
        end else if (!ph_if.busy) begin
          st_d = cwu_pkg::ST_ON;
        end
      end
      cwu_pkg::ST_ON: begin
        if (fall_ev) begin
          ph_if.len = work_fall_q[`CWU_PH];
          if (work_fall_q[`CWU_PH] == 8'h00) begin
            st_d = cwu_pkg::ST_OFF;
          end else begin
            st_d = cwu_pkg::ST_WAIT_OFF;
            ph_if.start = 1'b1;
          end
        end
      end
      cwu_pkg::ST_WAIT_OFF: begin
        ph_if.len = work_fall_q[`CWU_PH];
        if (!ph_if.busy) begin
          st_d = cwu_pkg::ST_OFF;
        end
      end
    endcase
    // shutdown or disable ends the active drive at once
    if (!run) begin
      st_d = cwu_pkg::ST_OFF;
      ph_if.start = 1'b0;
    end
  end

  assign drive_d = (st_d == cwu_pkg::ST_ON) || (st_d == cwu_pkg::ST_WAIT_OFF);
  assign ph_if.tick = gen_tick;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= cwu_pkg::ST_OFF;
      drive_q <= 1'b0;
      pin_sel_q <= 1'b1;
    end else begin
      st_q <= st_d;
      drive_q <= drive_d;
      if (drive_d && !drive_q) begin
        pin_sel_q <= !pin_sel_q;
      end
    end
  end

  // ==================================================
  // blanking and dead-band counters restart on each drive change
  assign bk_if.start = drive_d != drive_q;
  assign bk_if.len = drive_d ? work_rise_q[`CWU_BK] : work_fall_q[`CWU_BK];
  assign bk_if.tick = gen_tick;
  assign db_if.start = drive_d != drive_q;
  assign db_if.len = drive_d ? work_rise_q[`CWU_DB] : work_fall_q[`CWU_DB];
  assign db_if.tick = ctrl_q[`CWU_DBASY] ? 1'b1 : gen_tick;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bk_dir_q <= 1'b0;
    end else if (bk_if.start) begin
      bk_dir_q <= drive_d; // 1: after rise drive, masks falls
    end
  end

  // ==================================================
  // output pair: mode, dead band, override, polarity, enable
  always_comb begin
    if (ctrl_q[`CWU_PP]) begin
      act0 = drive_q && !pin_sel_q;
      act1 = drive_q && pin_sel_q;
    end else begin
      act0 = drive_q && !db_if.busy;
      act1 = !drive_q && !db_if.busy;
    end
  end
  assign drv0 = pin_drive(shdn_q[`CWU_SDACT], shdn_q[`CWU_OVR0], act0, ctrl_q[`CWU_POL0], ctrl_q[`CWU_OE0]);
  assign drv1 = pin_drive(shdn_q[`CWU_SDACT], shdn_q[`CWU_OVR1], act1, ctrl_q[`CWU_POL1], ctrl_q[`CWU_OE1]);

  // disabled generator releases both pins at their idle level
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out0_q <= 1'b0;
      oe0_q <= 1'b0;
      out1_q <= 1'b0;
      oe1_q <= 1'b0;
    end else if (!ctrl_q[`CWU_EN]) begin
      out0_q <= ctrl_q[`CWU_POL0];
      oe0_q <= 1'b0;
      out1_q <= ctrl_q[`CWU_POL1];
      oe1_q <= 1'b0;
    end else begin
      {out0_q, oe0_q} <= drv0;
      {out1_q, oe1_q} <= drv1;
    end
  end
  assign out0_out = out0_q;
  assign out0_oe_out = oe0_q;
  assign out1_out = out1_q;
  assign out1_oe_out = oe1_q;

  // ==================================================
  // assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_sync_no_overlap: assert property (!ctrl_q[`CWU_PP] |-> !(act0 && act1))
    else $error("both sync outputs active together");
  a_pp_one_pin: assert property (ctrl_q[`CWU_PP] |-> !(act0 && act1))
    else $error("push-pull drives both pins");
  a_pp_alternate: assert property ($rose(drive_q) |-> pin_sel_q != $past(pin_sel_q))
    else $error("pin not switched at new period");
  a_rise_starts: assert property (st_q == cwu_pkg::ST_OFF && run && rise_ev
      && work_rise_q[7:0] == 8'h00 |=> drive_q)
    else $error("rising event did not start drive");
  a_fall_ends: assert property (st_q == cwu_pkg::ST_ON && run && fall_ev
      && work_fall_q[7:0] == 8'h00 |=> !drive_q)
    else $error("falling event did not end drive");
  a_phase_waits: assert property (st_q == cwu_pkg::ST_OFF && run && rise_ev
      && work_rise_q[7:0] != 8'h00 |=> !drive_q ##1 !drive_q)
    else $error("phase delay skipped");
  a_blank_mask: assert property (bk_if.busy && bk_dir_q && !hlt_ev |-> !fall_ev)
    else $error("falling event passed blanking");
  a_fault_shutdown: assert property (fault_now |=> shdn_q[0] && !drive_q
      ##1 (out0_oe_out == (ctrl_q[`CWU_EN] && ctrl_q[`CWU_OE0] && shdn_q[3:2] != 2'h3)))
    else $error("fault did not shut down");
  a_auto_restart: assert property (shdn_q[`CWU_ARS] && !fault_now && !wr_go |=> !shdn_q[0])
    else $error("auto-restart did not clear shutdown");
  a_load_clears: assert property (xfer && !wr_ctrl |=> !ctrl_q[`CWU_LD] && work_rise_q == $past(rise_q))
    else $error("load bit not cleared after transfer");
  a_direct_load: assert property (!ctrl_q[`CWU_EN] |=> work_fall_q == $past(fall_q))
    else $error("disabled write did not reach working copy");
  a_sync_chain: assert property ($rose(rise_event_in) && !ctrl_q[`CWU_RLVL] |=> !rise_hit)
    else $error("raw input reached detector unsynchronised");

  c_pp_period: cover property (ctrl_q[`CWU_PP] && $rose(drive_q) ##[1:200] $rose(drive_q));
  c_shutdown: cover property ($rose(shdn_q[`CWU_SDACT]));
  c_load_xfer: cover property (xfer);
  c_dead_gap: cover property (!ctrl_q[`CWU_PP] && db_if.busy && !act0 && !act1);
endmodule // complementary_waveform_unit

// ### common/cwu_defines.svh
// register offsets, field positions, reset values and timing counts of the
// complementary waveform unit; assumes inclusion by bare name, no processes
`ifndef CWU_DEFINES_SVH
`define CWU_DEFINES_SVH
// ==================================================
// register byte offsets
`define CWU_CTRL_OFS 8'h00
`define CWU_SHDN_OFS 8'h04
`define CWU_RISE_OFS 8'h08
`define CWU_FALL_OFS 8'h0c
`define CWU_STAT_OFS 8'h10
// ==================================================
// control register fields
`define CWU_EN 0
`define CWU_PP 1
`define CWU_LD 2
`define CWU_OE0 3
`define CWU_OE1 4
`define CWU_POL0 5
`define CWU_POL1 6
`define CWU_RLVL 7
`define CWU_FLVL 8
`define CWU_FSAME 9
`define CWU_DBASY 10
`define CWU_CSEL 12:11
// ==================================================
// shutdown register fields
`define CWU_SDACT 0
`define CWU_ARS 1
`define CWU_OVR0 3:2
`define CWU_OVR1 5:4
`define CWU_FLTEN 6
`define CWU_HLTEN 7
// ==================================================
// rise and fall count register fields
`define CWU_PH 7:0
`define CWU_BK 15:8
`define CWU_DB 23:16
// ==================================================
// status register fields
`define CWU_ST_OUT0 0
`define CWU_ST_OUT1 1
`define CWU_ST_DRV 2
`define CWU_ST_PIN 3
`define CWU_ST_FLT 4
`define CWU_ST_STATE 11:8
// ==================================================
// writable masks and reset values
`define CWU_CTRL_MASK 32'h0000_1fff
`define CWU_SHDN_MASK 32'h0000_00ff
`define CWU_TIME_MASK 32'h00ff_ffff
`define CWU_CTRL_RST 32'h0000_0000
`define CWU_SHDN_RST 32'h0000_0001
`define CWU_TIME_RST 32'h0000_0000
// ==================================================
// timing: default divide ratio of the divided generator clock
`define CWU_CLK_DIV 4
`endif

// ### common/cwu_pkg.sv
// types shared by the complementary waveform unit
// assumes: compiled before every file that names cwu_pkg
package cwu_pkg;
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_WAIT_ON = 4'b0010,
    ST_ON = 4'b0100,
    ST_WAIT_OFF = 4'b1000
  } drive_state_t;
  typedef enum logic [1:0] {
    OVR_OFF = 2'h0,
    OVR_LOW = 2'h1,
    OVR_HIGH = 2'h2,
    OVR_HIZ = 2'h3
  } override_t;
  typedef enum logic [1:0] {
    CLK_SYS = 2'h0,
    CLK_DIVIDED = 2'h1,
    CLK_PIN = 2'h2
  } gen_clk_sel_t;
  typedef enum logic [2:0] {
    REG_CTRL = 3'h0,
    REG_SHDN = 3'h1,
    REG_RISE = 3'h2,
    REG_FALL = 3'h3,
    REG_STAT = 3'h4,
    REG_NONE = 3'h7
  } reg_sel_t;
endpackage

// ### common/cwu_timer_if.sv
// start/length/tick/busy bundle between the unit and one interval counter
// assumes: owner and counter share one clock
`timescale 1ns/10ps
interface cwu_timer_if #(parameter int unsigned W = 8);
  logic start;
  logic [W-1:0] len;
  logic tick;
  logic busy;
  modport owner (output start, output len, output tick, input busy);
  modport counter (input start, input len, input tick, output busy);
endinterface

// ### logic/interval_counter.sv
// down counter timing one phase, blanking or dead-band interval
// assumes: start is a one-cycle pulse from logic on sys_clk_in
`timescale 1ns/10ps
module interval_counter #(
  parameter int unsigned W = 8
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  cwu_timer_if.counter tmr
);
  logic [W-1:0] count_q;

  // ==================================================
  // counter
  // load on start, then one step per tick; zero means no interval
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_q <= '0;
    end else if (tmr.start) begin
      count_q <= tmr.len;
    end else if (tmr.tick && count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  // busy is registered only; a start-term here would close a loop
  assign tmr.busy = (count_q != '0);
endmodule // interval_counter

// ### verification/pwm_source_model.sv
// partner model: pwm source feeding both event inputs of the unit
// assumes: bench clock, run held low until the unit is configured
`timescale 1ns/10ps
module pwm_source_model #(
  parameter int unsigned HALF = 20
) (
  input wire logic clk_in,
  input wire logic run_in,
  output logic pwm_out
);
  int unsigned cnt_q;
  // ==========================================
  // square wave, both edges carried on one line
  always @(posedge clk_in) begin
    cnt_q <= (!run_in || cnt_q == 2 * HALF - 1) ? 0 : cnt_q + 1;
    pwm_out <= run_in && cnt_q < HALF;
  end
endmodule // pwm_source_model

// ### verification/complementary_output_generator_bench.sv
// bench for the complementary waveform unit: table of modes, then dead band, limit, fault
// assumes: 100 MHz clock, edge-sensed events, generator tick from the system clock
`timescale 1ns/10ps
`include "cwu_defines.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module complementary_output_generator_bench;
  logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready, fault, hardware_limit_timer, pwm, run;
  logic awready, wready, bvalid, arready, rvalid, o0, o0e, o1, o1e;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [1:0] bresp, rresp, r, hi, lo;
  int err_count, total_checks, cyc, i, p;
  // ctrl in the top half, then {out1,out0} high and low for two periods; push-pull first
  logic [31:0] rows [3] = '{32'h021b_1020, 32'h0219_1212, 32'h0279_2121};
  complementary_waveform_unit i_dut (.sys_clk_in(clk), .arst_n_in(arst_n),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata),
    .wstrb_in(4'hf), .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp),
    .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid),
    .rready_in(rready), .rise_event_in(pwm), .fall_event_in(pwm), .fault_in(fault),
    .hlt_event_in(hardware_limit_timer), .gen_clk_pin_in(1'b0), .out0_out(o0), .out0_oe_out(o0e),
    .out1_out(o1), .out1_oe_out(o1e));
  pwm_source_model i_src (.clk_in(clk), .run_in(run), .pwm_out(pwm));
  // ==========================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // axi4-lite access; every handshake judged at the rising edge, on the values standing before it
  // no local limit: only the bench's cycle guard ends a wait
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    bit fin;
    fin = 0;
    @(posedge clk);
    if (w) begin
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    end else begin
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    end
    while (!fin) begin
      @(posedge clk);
      if (w ? awvalid && awready : arvalid && arready) begin
        awvalid <= 1'b0; arvalid <= 1'b0;
      end
      if (wvalid && wready) wvalid <= 1'b0;
      fin = w ? bvalid : rvalid;
      q = rdata;
      r = w ? bresp : rresp;
    end
    bready <= 1'b0; rready <= 1'b0;
  endtask
  // one period: pin pair mid-high and mid-low of the source
  task automatic period;
    @(posedge pwm); repeat (15) @(posedge clk); #1 hi = {o1, o0};
    @(negedge pwm); repeat (15) @(posedge clk); #1 lo = {o1, o0};
  endtask
  // ==========================================
  // main sequence
  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready, fault, hardware_limit_timer, run} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    bus(0, `CWU_CTRL_OFS, 0); `CHK("ctrl reset", `CWU_CTRL_RST, q)
    bus(0, `CWU_SHDN_OFS, 0); `CHK("shdn reset", `CWU_SHDN_RST, q)
    bus(0, 8'h20, 0); `CHK("unmapped", 2'h2, r)
    bus(1, `CWU_SHDN_OFS, 32'h40);
    for (i = 0; i < 3; i++) begin
      bus(1, `CWU_CTRL_OFS, {16'h0, rows[i][31:16]});
      run <= 1'b1;
      for (p = 0; p < 2; p++) begin
        period();
        `CHK("pins high", rows[i][13 - 8 * p -: 2], hi)
        `CHK("pins low", rows[i][9 - 8 * p -: 2], lo)
      end
    end
    // dead band of six ticks, moved in by the load bit while running
    bus(1, `CWU_RISE_OFS, 32'h0006_0000);
    bus(1, `CWU_FALL_OFS, 32'h0006_0000);
    bus(1, `CWU_CTRL_OFS, 32'h021d);
    period();
    bus(0, `CWU_CTRL_OFS, 0); `CHK("load cleared", 32'h0219, q)
    @(posedge pwm); repeat (6) @(posedge clk); #1 `CHK("dead gap", 2'h0, {o1, o0})
    repeat (9) @(posedge clk); #1 `CHK("after gap", 2'h1, {o1, o0})
    // limit timer edge cuts the high half short
    bus(1, `CWU_SHDN_OFS, 32'hc0);
    @(posedge pwm); repeat (8) @(posedge clk); hardware_limit_timer <= 1'b1;
    repeat (4) @(posedge clk); hardware_limit_timer <= 1'b0;
    repeat (4) @(posedge clk); #1 `CHK("limit end", 1'b0, o0)
    // fault: out0 forced high, out1 released to hi-z
    bus(1, `CWU_SHDN_OFS, 32'h78);
    fault <= 1'b1;
    repeat (8) @(posedge clk); #1 `CHK("override", 3'b011, {o1e, o0e, o0})
    bus(1, `CWU_SHDN_OFS, 32'h4a);
    bus(0, `CWU_SHDN_OFS, 0); `CHK("fault holds", 1'b1, q[0])
    fault <= 1'b0;
    repeat (8) @(posedge clk);
    bus(0, `CWU_SHDN_OFS, 0); `CHK("restart", 1'b0, q[0])
    // rise phase of four ticks holds the drive back past the usual turn-on point
    bus(1, `CWU_RISE_OFS, 32'h0006_0004);
    bus(1, `CWU_CTRL_OFS, 32'h021d);
    period();
    @(posedge pwm); repeat (12) @(posedge clk); #1 `CHK("phase hold", 2'h0, {o1, o0})
    repeat (6) @(posedge clk); #1 `CHK("phase on", 2'h1, {o1, o0})
    conclude();
  end
endmodule // complementary_output_generator_bench
